/* File: core/crbv_params.svh */
`ifndef CRBV_PARAMS_SVH
`define CRBV_PARAMS_SVH
`define CRBV_ADDR_W        4
`define CRBV_OFS_INFO      4'h0
`define CRBV_OFS_IDENT     4'h4
`define CRBV_OFS_DATA_LO   4'h8
`define CRBV_OFS_DATA_HI   4'hC
`define CRBV_OFS_STATUS    4'h1
`define CRBV_OFS_COMMAND   4'h2
`define CRBV_BIT_FORMAT    31
`define CRBV_BIT_REMOTE    30
`define CRBV_BIT_BYPASS    10
`define CRBV_BIT_AVAIL     0
`define CRBV_BIT_OVERRUN   1
`define CRBV_BIT_RELEASE   2
`define CRBV_BIT_CLR_OVR   3
`define CRBV_MAX_BYTES     4'h8
`define CRBV_LEN_MSB       19
`define CRBV_LEN_LSB       16
`define CRBV_IDX_MSB       9
`define CRBV_ID_MSB        28
`define CRBV_LANES         8
`endif

/* File: core/crbv_pkg.sv */
package crbv_pkg;
  typedef struct packed {
    logic        extended_format_flag;
    logic        remote_flag;
    logic [3:0]  length_code;
    logic        filter_bypassed_flag;
    logic [9:0]  filter_match_index;
    logic [28:0] received_identifier;
    logic [63:0] rx_bytes;
  } crbv_frame_t;
endpackage

/* File: core/crbv_top.sv */
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "crbv_params.svh"
module crbv_top (
  input  wire logic                    clock_in,
  input  wire logic                    rstn_in,
  input  wire logic [`CRBV_ADDR_W-1:0] addr_in,
  input  wire logic [31:0]             wdata_in,
  input  wire logic                    wr_in,
  input  wire logic                    rd_in,
  output logic      [31:0]             rdata_out,
  input  wire logic                    frame_valid_in,
  input  wire crbv_pkg::crbv_frame_t   frame_in,
  output logic                         rx_message_available_out,
  output logic                         rx_overrun_flag_out
);
  import crbv_pkg::*;

  // Address decode
  logic        hit_info;
  logic        hit_ident;
  logic        hit_data_lo;
  logic        hit_data_hi;
  logic        hit_status;
  logic        hit_command;

  // Command strobes
  logic        wr_cmd;
  logic        release_cmd;
  logic        clr_ovr_cmd;

  // Where an incoming frame goes this cycle
  logic        front_busy;
  logic        back_busy;
  logic        store_front;
  logic        store_back;
  logic        frame_lost;

  // Double receive buffer; the front slot is the software view
  crbv_frame_t front_r;
  crbv_frame_t front_nxt;
  logic        front_v_r;
  logic        front_v_nxt;
  crbv_frame_t back_r;
  crbv_frame_t back_nxt;
  logic        back_v_r;
  logic        back_v_nxt;

  // Sticky loss flag
  logic        ovr_r;
  logic        ovr_nxt;

  // Fields of the front slot
  logic        fmt_bit;
  logic        remote_bit;
  logic [3:0]  len_field;
  logic        bypass_bit;
  logic [9:0]  index_field;
  logic [28:0] ident_field;

  // Byte lanes of the front slot
  logic [3:0]  eff_len;
  logic [7:0]  lane_valid;
  logic [7:0]  lane_byte [8];
  logic [63:0] masked;
  logic [7:0]  rx_byte_one;
  logic [7:0]  rx_byte_two;
  logic [7:0]  rx_byte_three;
  logic [7:0]  rx_byte_four;
  logic [7:0]  rx_byte_five;
  logic [7:0]  rx_byte_six;
  logic [7:0]  rx_byte_seven;
  logic [7:0]  rx_byte_eight;

  // Words as software reads them
  logic [31:0] info_w;
  logic [31:0] ident_w;
  logic [31:0] lo_w;
  logic [31:0] hi_w;
  logic [31:0] status_w;
  logic [31:0] sel_word;

  // Registered read port
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  always_comb begin
    hit_info    = 1'b0;
    hit_ident   = 1'b0;
    hit_data_lo = 1'b0;
    hit_data_hi = 1'b0;
    hit_status  = 1'b0;
    hit_command = 1'b0;

    if (addr_in == `CRBV_OFS_INFO) begin
      hit_info = 1'b1;
    end else if (addr_in == `CRBV_OFS_IDENT) begin
      hit_ident = 1'b1;
    end else if (addr_in == `CRBV_OFS_DATA_LO) begin
      hit_data_lo = 1'b1;
    end else if (addr_in == `CRBV_OFS_DATA_HI) begin
      hit_data_hi = 1'b1;
    end else if (addr_in == `CRBV_OFS_STATUS) begin
      hit_status = 1'b1;
    end else if (addr_in == `CRBV_OFS_COMMAND) begin
      hit_command = 1'b1;
    end
  end

  // Writes act only at the command offset; receive words ignore them
  assign wr_cmd      = wr_in && hit_command;
  assign release_cmd = wr_cmd && wdata_in[`CRBV_BIT_RELEASE];
  assign clr_ovr_cmd = wr_cmd && wdata_in[`CRBV_BIT_CLR_OVR];

  // A release frees its slot before a same-cycle frame is placed
  always_comb begin
    front_busy = front_v_r;
    back_busy  = back_v_r;

    if (release_cmd) begin
      front_busy = back_v_r;
      back_busy  = 1'b0;
    end
    store_front = frame_valid_in && !front_busy;
    store_back  = frame_valid_in && front_busy && !back_busy;
    frame_lost  = frame_valid_in && front_busy && back_busy;
  end

  // Front slot
  always_comb begin
    front_nxt   = front_r;
    front_v_nxt = front_v_r;

    if (release_cmd) begin
      // Whole frame moves at once from the back slot
      front_nxt   = back_r;
      front_v_nxt = back_v_r;
    end
    if (store_front) begin
      front_nxt   = frame_in;
      front_v_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      front_r   <= '0;
      front_v_r <= 1'b0;
    end else begin
      front_r   <= front_nxt;
      front_v_r <= front_v_nxt;
    end
  end

  // Back slot
  always_comb begin
    back_nxt   = back_r;
    back_v_nxt = back_v_r;

    if (release_cmd) begin
      back_v_nxt = 1'b0;
    end
    if (store_back) begin
      back_nxt   = frame_in;
      back_v_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      back_r   <= '0;
      back_v_r <= 1'b0;
    end else begin
      back_r   <= back_nxt;
      back_v_r <= back_v_nxt;
    end
  end

  // A lost frame sets the flag even when a clear arrives alongside
  always_comb begin
    ovr_nxt = ovr_r;

    if (clr_ovr_cmd) begin
      ovr_nxt = 1'b0;
    end
    if (frame_lost) begin
      ovr_nxt = 1'b1;
    end
  end

  // Loss flag register
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ovr_r <= 1'b0;
    end else begin
      ovr_r <= ovr_nxt;
    end
  end

  // Field view
  always_comb begin
    fmt_bit     = front_r.extended_format_flag;
    remote_bit  = front_r.remote_flag;
    len_field   = front_r.length_code;
    bypass_bit  = front_r.filter_bypassed_flag;
    index_field = front_r.filter_match_index;
    ident_field = front_r.received_identifier;
  end

  // Codes above eight behave as eight
  always_comb begin
    eff_len = len_field;
    if (len_field > `CRBV_MAX_BYTES) begin
      eff_len = `CRBV_MAX_BYTES;
    end
  end

  // Lanes past the effective length read zero
  for (genvar g = 0; g < `CRBV_LANES; g++) begin : g_lane
    assign lane_byte[g]     = front_r.rx_bytes[g*8 +: 8];
    assign lane_valid[g]    = (eff_len > 4'(g));
    assign masked[g*8 +: 8] = lane_valid[g] ? lane_byte[g] : 8'h00;
  end

  always_comb begin
    rx_byte_one   = masked[7:0];
    rx_byte_two   = masked[15:8];
    rx_byte_three = masked[23:16];
    rx_byte_four  = masked[31:24];
    rx_byte_five  = masked[39:32];
    rx_byte_six   = masked[47:40];
    rx_byte_seven = masked[55:48];
    rx_byte_eight = masked[63:56];
  end

  // Index passed on as counted by the filter, disabled entries included
  always_comb begin
    info_w                              = 32'h0000_0000;
    info_w[`CRBV_BIT_FORMAT]            = fmt_bit;
    info_w[`CRBV_BIT_REMOTE]            = remote_bit;
    info_w[29:20]                       = 10'h000;
    info_w[`CRBV_LEN_MSB:`CRBV_LEN_LSB] = len_field;
    info_w[15:11]                       = 5'h00;
    info_w[`CRBV_BIT_BYPASS]            = bypass_bit;
    info_w[`CRBV_IDX_MSB:0]             = index_field;
  end

  // Standard ids arrive right aligned in the low 11 bits
  always_comb begin
    ident_w                 = 32'h0000_0000;
    ident_w[31:29]          = 3'h0;
    ident_w[`CRBV_ID_MSB:0] = ident_field;
  end

  assign lo_w = {rx_byte_four, rx_byte_three, rx_byte_two, rx_byte_one};
  assign hi_w = {rx_byte_eight, rx_byte_seven, rx_byte_six, rx_byte_five};

  always_comb begin
    status_w                    = 32'h0000_0000;
    status_w[`CRBV_BIT_AVAIL]   = front_v_r;
    status_w[`CRBV_BIT_OVERRUN] = ovr_r;
  end

  // Unmapped offsets select zero
  always_comb begin
    sel_word = 32'h0000_0000;

    if (hit_info) begin
      sel_word = info_w;
    end else if (hit_ident) begin
      sel_word = ident_w;
    end else if (hit_data_lo) begin
      sel_word = lo_w;
    end else if (hit_data_hi) begin
      sel_word = hi_w;
    end else if (hit_status) begin
      sel_word = status_w;
    end
  end

  // Data stand one cycle after the strobe; idle cycles read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rd_in) begin
      rdata_nxt = sel_word;
    end
  end

  // Read data register
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_out                = rdata_r;
  assign rx_message_available_out = front_v_r;
  assign rx_overrun_flag_out      = ovr_r;
endmodule
`default_nettype wire

/* File: sim/can_receive_buffer_view_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module can_receive_buffer_view_tb;
  import crbv_pkg::*;
  logic        clock_in = '0, rstn_in = '0, wr_in = '0, rd_in = '0, frame_valid_in = '0, rd_d = '0;
  logic [3:0]  addr_in = '0;
  logic [31:0] wdata_in = '0, rdata_out, exp_q[$];
  logic        rx_message_available_out, rx_overrun_flag_out;
  crbv_frame_t frame_in = '0, fa, fb;
  int          n_mismatch, total_checks, cyc;
  crbv_top crbv_top_inst (
    .clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .frame_valid_in(frame_valid_in),
    .frame_in(frame_in), .rx_message_available_out(rx_message_available_out),
    .rx_overrun_flag_out(rx_overrun_flag_out));
  initial forever #5 clock_in = ~clock_in;
  task end_of_test;
    $display("%0d checks %0d mismatches", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clock_in) begin
    if (rd_d) begin
      total_checks++;
      if (rdata_out !== exp_q.pop_front()) begin
        n_mismatch++;
        $display("[FAIL] %0t read %h", $time, rdata_out);
      end
    end
    rd_d <= rd_in;
    cyc <= cyc + 1;
    if (cyc == 400) begin
      n_mismatch++;
      end_of_test;
    end
  end
  task bus(logic w, logic [3:0] a, logic [31:0] d);
    @(posedge clock_in);
    {wr_in, rd_in, addr_in, wdata_in} <= {w, !w, a, d};
    if (!w) exp_q.push_back(d);
    @(posedge clock_in);
    {wr_in, rd_in} <= 2'h0;
  endtask
  task fr(crbv_frame_t f);
    @(posedge clock_in);
    {frame_valid_in, frame_in} <= {1'h1, f};
    @(posedge clock_in);
    frame_valid_in <= 1'h0;
  endtask
  // Command write and frame in the same cycle
  task both(logic [31:0] c, crbv_frame_t f);
    @(posedge clock_in);
    {wr_in, addr_in, wdata_in, frame_valid_in, frame_in} <= {1'h1, 4'h2, c, 1'h1, f};
    @(posedge clock_in);
    {wr_in, frame_valid_in} <= 2'h0;
  endtask
  // Bytes past the effective length read zero
  function automatic logic [31:0] wd(crbv_frame_t f, int k);
    logic [63:0] b;
    for (int i = 0; i < 8; i++) b[i*8+:8] = i < f.length_code ? f.rx_bytes[i*8+:8] : 8'h0;
    return k == 0 ? {f.extended_format_flag, f.remote_flag, 10'h0, f.length_code, 5'h0,
                     f.filter_bypassed_flag, f.filter_match_index}
         : k == 1 ? {3'h0, f.received_identifier} : k == 2 ? b[31:0] : b[63:32];
  endfunction
  task chk(crbv_frame_t f);
    for (int k = 0; k < 4; k++) bus(1'h0, 4'(k * 4), wd(f, k));
  endtask
  initial begin
    void'($urandom(93));
    fa = 110'({$urandom, $urandom, $urandom, $urandom});
    fb = 110'({$urandom, $urandom, $urandom, $urandom});
    {fa.extended_format_flag, fa.received_identifier[28:11], fa.length_code} = {19'h0, 4'h3};
    fb.length_code = 4'hC;
    repeat (5) @(posedge clock_in);
    rstn_in <= 1'h1;
    chk('0);
    fr(fa);
    chk(fa);
    for (int k = 0; k < 4; k++) bus(1'h1, 4'(k * 4), '1);
    chk(fa);
    fr(fb);
    fr(fa);
    bus(1'h0, 4'h1, 32'h3);
    bus(1'h1, 4'h2, 32'h4);
    chk(fb);
    bus(1'h1, 4'h2, 32'hC);
    bus(1'h0, 4'h1, 32'h0);
    bus(1'h0, 4'h3, 32'h0);
    fr(fb);
    fr(fa);
    both(32'h8, fb);
    bus(1'h0, 4'h1, 32'h3);
    both(32'h4, fb);
    chk(fa);
    bus(1'h0, 4'h1, 32'h3);
    bus(1'h1, 4'h2, 32'h4);
    chk(fb);
    repeat (2) @(posedge clock_in);
    end_of_test;
  end
endmodule
bind crbv_top crbv_props crbv_props_inst (
  .clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .frame_valid_in(frame_valid_in),
  .rx_message_available_out(rx_message_available_out),
  .rx_overrun_flag_out(rx_overrun_flag_out));
`default_nettype wire

/* File: sim/crbv_props.sv */
`timescale 1ns/1ps
`default_nettype none
module crbv_props (
  input wire logic        clock_in,
  input wire logic        rstn_in,
  input wire logic [3:0]  addr_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic        frame_valid_in,
  input wire logic        rx_message_available_out,
  input wire logic        rx_overrun_flag_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  sequence s_rd(logic [3:0] a); rd_in && addr_in == a; endsequence
  property p_i; s_rd(4'h0) |=> !rdata_out[29:20] && !rdata_out[15:11]; endproperty
  a_i: assert property (p_i) else $error("info rsv");
  property p_d; s_rd(4'h4) |=> !rdata_out[31:29]; endproperty
  a_d: assert property (p_d) else $error("id rsv");
  property p_u; s_rd(4'h3) |=> !rdata_out; endproperty
  a_u: assert property (p_u) else $error("unmapped");
  property p_s;
    s_rd(4'h1) |=> rdata_out == {30'h0, $past(rx_overrun_flag_out), $past(rx_message_available_out)};
  endproperty
  a_s: assert property (p_s) else $error("status");
  property p_a; frame_valid_in |=> rx_message_available_out; endproperty
  a_a: assert property (p_a) else $error("avail");
  property p_o; rx_overrun_flag_out && !wr_in |=> rx_overrun_flag_out; endproperty
  a_o: assert property (p_o) else $error("sticky");
  property p_n; !rx_overrun_flag_out && !frame_valid_in |=> !rx_overrun_flag_out; endproperty
  a_n: assert property (p_n) else $error("ovr set");
  property p_r; $rose(rx_overrun_flag_out) |-> $past(rx_message_available_out); endproperty
  a_r: assert property (p_r) else $error("ovr cause");
endmodule
`default_nettype wire
